// >>> logic/eeprom_pkg.sv
package eeprom_pkg;
   // ************************************************************
   // special function register map
   // ************************************************************
   localparam int DATA_W = 8;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_ADDRESS = 8'h09;
   localparam logic [7:0] REG_CONTROL = 8'h88;
   localparam logic [7:0] REG_UNLOCK = 8'h89;

   // control/status bit positions
   localparam int CTRL_RD = 0;
   localparam int CTRL_WR = 1;
   localparam int CTRL_WRITE_ENABLE_BIT = 2;
   localparam int CTRL_ERR = 3;
   localparam int CTRL_DONE = 4;

   // ************************************************************
   // storage and unlock constants
   // ************************************************************
   localparam int MEM_DEPTH = 64;
   localparam int MEM_AW = 6;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [1:0] UPPER_ADDR_OK = 2'h0;

   // ************************************************************
   // write timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int WRITE_TIME_US = 10;
   localparam int WRITE_CYCLES_DEFAULT =
      (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int TIMER_W = 20;
   localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h0_0001;
   localparam logic [TIMER_W-1:0] TIMER_ZERO = 20'h0_0000;

   // ************************************************************
   // state encodings
   // ************************************************************
   typedef enum logic [2:0]
   {
      WS_IDLE = 3'h1,
      WS_ERASE = 3'h2,
      WS_PROGRAM = 3'h4
   } write_state_t;

   typedef enum logic [2:0]
   {
      UNL_IDLE = 3'h1,
      UNL_KEY1 = 3'h2,
      UNL_ARMED = 3'h4
   } unlock_state_t;
endpackage : eeprom_pkg

// >>> logic/eeprom_array_if.sv
// ************************************************************
// access lines between the controller and the storage cells
// ************************************************************
interface eeprom_array_if;
   import eeprom_pkg::*;
   logic [MEM_AW-1:0] addr;
   logic sel;
   logic [DATA_W-1:0] wdata;
   logic erase;
   logic write_cell;
   logic [DATA_W-1:0] rdata;

   modport ctrl
   (
      output addr,
      output sel,
      output wdata,
      output erase,
      output write_cell,
      input rdata
   );

   modport cells
   (
      input addr,
      input sel,
      input wdata,
      input erase,
      input write_cell,
      output rdata
   );
endinterface : eeprom_array_if

// >>> logic/eeprom_cells.sv
// ************************************************************
// 64-byte storage; read is combinational so data lands in one cycle
// ************************************************************
module eeprom_cells
(
   input wire logic core_clk,
   eeprom_array_if.cells bus
);
   import eeprom_pkg::*;

   logic [DATA_W-1:0] mem [MEM_DEPTH];

   // erase forces all ones, program then stores the byte
   always_ff @(posedge core_clk)
   begin
      if (bus.sel && bus.erase)
      begin
         mem[bus.addr] <= ERASED_BYTE;
      end
      else if (bus.sel && bus.write_cell)
      begin
         mem[bus.addr] <= bus.wdata;
      end
   end

   // unimplemented upper locations read as zero
   assign bus.rdata = bus.sel ? mem[bus.addr] : ZERO_BYTE;
endmodule : eeprom_cells

// >>> logic/write_timer.sv
// ************************************************************
// self timer: expired pulses exactly load + 1 cycles after start
// ************************************************************
module write_timer
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic abort,
   input wire logic [eeprom_pkg::TIMER_W-1:0] load,
   output logic expired
);
   import eeprom_pkg::*;

   logic [TIMER_W-1:0] count;
   logic [TIMER_W-1:0] next_count;
   logic next_expired;

   // abort drops the count so a stale expiry never follows a reset
   always_comb
   begin
      next_count = count;
      next_expired = 1'b0;
      if (abort)
      begin
         next_count = TIMER_ZERO;
      end
      else if (start)
      begin
         next_count = load;
      end
      else if (count != TIMER_ZERO)
      begin
         next_count = count - TIMER_ONE;
         next_expired = (count == TIMER_ONE);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         count <= TIMER_ZERO;
         expired <= 1'b0;
      end
      else
      begin
         count <= next_count;
         expired <= next_expired;
      end
   end
endmodule : write_timer

// >>> logic/data_eeprom_access_control.sv
module data_eeprom_access_control
#(
   parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEFAULT
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic master_clear_reset,
   input wire logic watchdog_reset_source,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [eeprom_pkg::DATA_W-1:0] sfr_wdata,
   output logic [eeprom_pkg::DATA_W-1:0] sfr_rdata,
   input wire logic code_protect,
   input wire logic prog_req,
   input wire logic prog_write,
   input wire logic [eeprom_pkg::MEM_AW-1:0] prog_addr,
   input wire logic [eeprom_pkg::DATA_W-1:0] prog_wdata,
   output logic [eeprom_pkg::DATA_W-1:0] prog_rdata,
   output logic prog_ack,
   output logic prog_denied
);
   import eeprom_pkg::*;

   localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(WRITE_CYCLES / 2);
   localparam logic [TIMER_W-1:0] PROGRAM_LOAD =
      TIMER_W'(WRITE_CYCLES - WRITE_CYCLES / 2);

   // ************************************************************
   // state
   // ************************************************************
   write_state_t state, next_state;
   unlock_state_t unlock, next_unlock;
   logic [DATA_W-1:0] eeprom_data, next_eeprom_data;
   logic [DATA_W-1:0] eeprom_address, next_eeprom_address;
   logic rd_bit, next_rd_bit;
   logic wr_bit, next_wr_bit;
   logic write_enable_bit, next_write_enable_bit;
   logic write_abort_error, next_write_abort_error;
   logic write_complete_flag, next_write_complete_flag;
   logic [DATA_W-1:0] next_sfr_rdata, next_prog_rdata;
   logic next_prog_ack, next_prog_denied;

   logic dev_reset, busy, ctrl_wr, start_write, expired;
   logic timer_start, prog_ok, finish;
   logic [TIMER_W-1:0] timer_load;
   logic [DATA_W-1:0] ctrl_view;

   eeprom_array_if arr ();

   eeprom_cells u_cells
   (
      .core_clk(core_clk),
      .bus(arr)
   );

   write_timer u_timer
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .start(timer_start),
      .abort(dev_reset),
      .load(timer_load),
      .expired(expired)
   );

   // ************************************************************
   // decode and qualifiers
   // ************************************************************
   assign dev_reset = master_clear_reset | watchdog_reset_source;
   assign busy = (state != WS_IDLE);
   assign ctrl_wr = sfr_wr && (sfr_addr == REG_CONTROL);
   // enable is the stored bit, not the one written alongside
   assign start_write = ctrl_wr && sfr_wdata[CTRL_WR] && !busy &&
      (unlock == UNL_ARMED) && write_enable_bit &&
      !dev_reset;
   assign finish = (state == WS_PROGRAM) && expired && !dev_reset;
   // programmer access only when core is idle and not protected
   assign prog_ok = prog_req && !code_protect && !busy && !rd_bit;

   // ************************************************************
   // unlock sequence: any other write in between disarms it
   // ************************************************************
   always_comb
   begin
      next_unlock = unlock;
      if (dev_reset)
      begin
         next_unlock = UNL_IDLE;
      end
      else if (sfr_wr)
      begin
         next_unlock = UNL_IDLE;
         if (sfr_addr == REG_UNLOCK && sfr_wdata == UNLOCK_KEY1)
         begin
            next_unlock = UNL_KEY1;
         end
         else if (sfr_addr == REG_UNLOCK && sfr_wdata == UNLOCK_KEY2 &&
            unlock == UNL_KEY1)
         begin
            next_unlock = UNL_ARMED;
         end
      end
   end

   // ************************************************************
   // write sequencer: erase phase then program phase
   // ************************************************************
   always_comb
   begin
      next_state = state;
      timer_start = 1'b0;
      timer_load = ERASE_LOAD;
      case (state)
         WS_IDLE:
         begin
            if (start_write)
            begin
               next_state = WS_ERASE;
               timer_start = 1'b1;
            end
         end
         WS_ERASE:
         begin
            if (dev_reset)
            begin
               next_state = WS_IDLE;
            end
            else if (expired)
            begin
               next_state = WS_PROGRAM;
               timer_start = 1'b1;
               timer_load = PROGRAM_LOAD;
            end
         end
         WS_PROGRAM:
         begin
            if (dev_reset || expired)
            begin
               next_state = WS_IDLE;
            end
         end
         default:
         begin
            next_state = WS_IDLE;
         end
      endcase
   end

   // ************************************************************
   // cell access; upper address bits must be zero to hit a cell
   // ************************************************************
   always_comb
   begin
      arr.addr = eeprom_address[MEM_AW-1:0];
      arr.sel = (eeprom_address[DATA_W-1:MEM_AW] == UPPER_ADDR_OK);
      arr.wdata = eeprom_data;
      arr.erase = (state == WS_ERASE) && expired && !dev_reset;
      arr.write_cell = finish;
      if (prog_ok)
      begin
         arr.addr = prog_addr;
         arr.sel = 1'b1;
         arr.wdata = prog_wdata;
         arr.write_cell = prog_write;
      end
   end

   // ************************************************************
   // control/status, address and data registers
   // ************************************************************
   always_comb
   begin
      next_eeprom_data = eeprom_data;
      next_eeprom_address = eeprom_address;
      next_rd_bit = 1'b0;
      next_wr_bit = wr_bit;
      next_write_enable_bit = write_enable_bit;
      next_write_abort_error = write_abort_error;
      next_write_complete_flag = write_complete_flag;
      if (sfr_wr && sfr_addr == REG_DATA)
      begin
         next_eeprom_data = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == REG_ADDRESS)
      begin
         next_eeprom_address = sfr_wdata;
      end
      if (rd_bit)
      begin
         next_eeprom_data = arr.rdata;
      end
      if (ctrl_wr)
      begin
         next_write_enable_bit = sfr_wdata[CTRL_WRITE_ENABLE_BIT];
         next_write_abort_error = sfr_wdata[CTRL_ERR];
         next_write_complete_flag = sfr_wdata[CTRL_DONE];
         // software may only set read start, and not mid-write
         next_rd_bit = sfr_wdata[CTRL_RD] && !busy;
      end
      if (start_write)
      begin
         next_wr_bit = 1'b1;
      end
      // completion beats a same-cycle software clear of the flag
      if (finish)
      begin
         next_wr_bit = 1'b0;
         next_write_complete_flag = 1'b1;
         next_write_abort_error = 1'b0;
      end
      // device resets clear controls; error records a cut write
      if (dev_reset)
      begin
         next_rd_bit = 1'b0;
         next_wr_bit = 1'b0;
         next_write_enable_bit = 1'b0;
         next_write_complete_flag = 1'b0;
         next_write_abort_error = busy ? 1'b1 : write_abort_error;
      end
   end

   // ************************************************************
   // read-back and programmer answers
   // ************************************************************
   always_comb
   begin
      ctrl_view = ZERO_BYTE;
      ctrl_view[CTRL_RD] = rd_bit;
      ctrl_view[CTRL_WR] = wr_bit;
      ctrl_view[CTRL_WRITE_ENABLE_BIT] = write_enable_bit;
      ctrl_view[CTRL_ERR] = write_abort_error;
      ctrl_view[CTRL_DONE] = write_complete_flag;
      next_sfr_rdata = sfr_rdata;
      if (sfr_rd)
      begin
         case (sfr_addr)
            REG_DATA: next_sfr_rdata = eeprom_data;
            REG_ADDRESS: next_sfr_rdata = eeprom_address;
            REG_CONTROL: next_sfr_rdata = ctrl_view;
            default: next_sfr_rdata = ZERO_BYTE;
         endcase
      end
      next_prog_ack = prog_ok;
      next_prog_denied = prog_req && code_protect;
      next_prog_rdata = prog_ok ? arr.rdata : prog_rdata;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= WS_IDLE;
         unlock <= UNL_IDLE;
         eeprom_data <= ZERO_BYTE;
         eeprom_address <= ZERO_BYTE;
         rd_bit <= 1'b0;
         wr_bit <= 1'b0;
         write_enable_bit <= 1'b0;
         write_abort_error <= 1'b0;
         write_complete_flag <= 1'b0;
         sfr_rdata <= ZERO_BYTE;
         prog_rdata <= ZERO_BYTE;
         prog_ack <= 1'b0;
         prog_denied <= 1'b0;
      end
      else
      begin
         state <= next_state;
         unlock <= next_unlock;
         eeprom_data <= next_eeprom_data;
         eeprom_address <= next_eeprom_address;
         rd_bit <= next_rd_bit;
         wr_bit <= next_wr_bit;
         write_enable_bit <= next_write_enable_bit;
         write_abort_error <= next_write_abort_error;
         write_complete_flag <= next_write_complete_flag;
         sfr_rdata <= next_sfr_rdata;
         prog_rdata <= next_prog_rdata;
         prog_ack <= next_prog_ack;
         prog_denied <= next_prog_denied;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_rd_self_clear;
      rd_bit |=> !rd_bit;
   endproperty
   a_rd_self_clear: assert property (p_rd_self_clear)
      else $error("read start bit not cleared");

   property p_read_loads_data;
      rd_bit |=> eeprom_data == $past(arr.rdata);
   endproperty
   a_read_loads_data: assert property (p_read_loads_data)
      else $error("read did not load data register");

   property p_ctrl_upper_zero;
      sfr_rd && sfr_addr == REG_CONTROL |=> sfr_rdata[7:5] == 3'h0;
   endproperty
   a_ctrl_upper_zero: assert property (p_ctrl_upper_zero)
      else $error("control upper bits not zero");

   property p_start_needs_unlock;
      $rose(wr_bit) |-> $past(unlock) == UNL_ARMED;
   endproperty
   a_start_needs_unlock: assert property (p_start_needs_unlock)
      else $error("write started without unlock");

   property p_start_needs_enable;
      $rose(wr_bit) |-> $past(write_enable_bit);
   endproperty
   a_start_needs_enable: assert property (p_start_needs_enable)
      else $error("write started with enable clear");

   property p_done_flags;
      finish |=> write_complete_flag && !write_abort_error && !wr_bit;
   endproperty
   a_done_flags: assert property (p_done_flags)
      else $error("completion flags wrong");

   property p_abort_error;
      dev_reset && busy |=> write_abort_error && !wr_bit && !busy;
   endproperty
   a_abort_error: assert property (p_abort_error)
      else $error("aborted write did not flag error");

   property p_wr_held;
      wr_bit && !finish && !dev_reset |=> wr_bit;
   endproperty
   a_wr_held: assert property (p_wr_held)
      else $error("write start bit dropped early");

   property p_erase_before_program;
      $rose(state == WS_PROGRAM) |-> $past(arr.erase);
   endproperty
   a_erase_before_program: assert property (p_erase_before_program)
      else $error("program phase without erase");

   property p_busy_no_read;
      busy && ctrl_wr |=> !rd_bit;
   endproperty
   a_busy_no_read: assert property (p_busy_no_read)
      else $error("read started during write");

   property p_protect_denies;
      prog_req && code_protect |=> prog_denied && !prog_ack;
   endproperty
   a_protect_denies: assert property (p_protect_denies)
      else $error("programmer not denied under protection");

   c_read: cover property (rd_bit ##1 !rd_bit);
   c_write_done: cover property (finish ##1 write_complete_flag);
   c_write_abort: cover property (busy && dev_reset ##1 write_abort_error);
endmodule : data_eeprom_access_control

// >>> verification/core_model.sv
// ************************************************************
// processor core side: register bus cycles on the falling edge
// ************************************************************
module core_model
(
   input wire logic core_clk,
   output logic [7:0] sfr_addr,
   output logic sfr_wr,
   output logic sfr_rd,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import eeprom_pkg::*;

   // idle bus at time zero
   initial
   begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
   end

   // one-cycle strobe; released lines flip so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
      sfr_addr = ~a;
      sfr_wdata = ~d;
   endtask : wr

   // read data is registered, so it is settled one falling edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
      sfr_addr = ~a;
   endtask : rd

   // full byte write: data, address, enable, both keys, then start
   task automatic unlock_write(input logic [7:0] a, input logic [7:0] d);
      wr(REG_DATA, d);
      wr(REG_ADDRESS, a);
      wr(REG_CONTROL, 8'h04);
      wr(REG_UNLOCK, UNLOCK_KEY1);
      wr(REG_UNLOCK, UNLOCK_KEY2);
      wr(REG_CONTROL, 8'h06);
   endtask : unlock_write
endmodule : core_model

// >>> verification/data_eeprom_access_control_tb_top.sv
module data_eeprom_access_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import eeprom_pkg::*;

   // ************************************************************
   // clock, reset, design and core model
   // ************************************************************
   logic core_clk, sys_rst, master_clear_reset, watchdog_reset_source;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, prog_wdata, prog_rdata;
   logic sfr_wr, sfr_rd, code_protect, prog_req, prog_write;
   logic prog_ack, prog_denied;
   logic [5:0] prog_addr;
   int err_count = 0;
   int comparisons = 0;
   int cycle_count = 0;

   // short timer keeps every write to a few dozen cycles
   data_eeprom_access_control #(.WRITE_CYCLES(16)) uut
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .master_clear_reset(master_clear_reset),
      .watchdog_reset_source(watchdog_reset_source),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .code_protect(code_protect),
      .prog_req(prog_req),
      .prog_write(prog_write),
      .prog_addr(prog_addr),
      .prog_wdata(prog_wdata),
      .prog_rdata(prog_rdata),
      .prog_ack(prog_ack),
      .prog_denied(prog_denied)
   );

   core_model core
   (
      .core_clk(core_clk),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata)
   );

   initial core_clk = 1'b0;
   always #10 core_clk = ~core_clk;

   // hang guard, far above the expected run length
   always @(posedge core_clk)
   begin
      cycle_count++;
      if (cycle_count == 20000)
      begin
         err_count++;
         give_verdict();
      end
   end

   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      core.rd(a, v);
      check($sformatf("register %h", a), v, exp);
   endtask : expect_reg

   // poll write-start bit with a bounded count
   task automatic wait_idle();
      logic [7:0] v;
      int n;
      n = 0;
      do
      begin
         core.rd(REG_CONTROL, v);
         n++;
      end
      while (v[CTRL_WR] !== 1'b0 && n < 64);
      check("write start cleared", {7'h00, v[CTRL_WR]}, 8'h00);
   endtask : wait_idle

   // read a cell through address, read-start and data register
   task automatic expect_cell(input logic [7:0] a, input logic [7:0] exp);
      core.wr(REG_ADDRESS, a);
      core.wr(REG_CONTROL, 8'h01);
      expect_reg(REG_DATA, exp);
   endtask : expect_cell

   task automatic prog(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
      @(negedge core_clk);
      prog_req = 1'b1;
      prog_write = w;
      prog_addr = a;
      prog_wdata = d;
      @(negedge core_clk);
      prog_req = 1'b0;
      prog_wdata = ~d;
   endtask : prog

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset_values();
      logic [7:0] regs [6] = '{8'h08, 8'h09, 8'h88, 8'h89, 8'h00, 8'hFF};
      foreach (regs[i])
         expect_reg(regs[i], 8'h00);
   endtask : t_reset_values

   task automatic t_write_readback();
      logic [7:0] a, d;
      for (int i = 0; i < 2; i++)
      begin
         a = (i == 0) ? 8'h00 : 8'h3F;
         d = (i == 0) ? 8'hA5 : 8'h5C;
         core.unlock_write(a, d);
         expect_reg(REG_CONTROL, 8'h06);
         wait_idle();
         expect_reg(REG_CONTROL, 8'h14);
         core.wr(REG_CONTROL, 8'h04);
         expect_reg(REG_CONTROL, 8'h04);
         expect_cell(a, d);
         expect_reg(REG_CONTROL, 8'h00);
      end
   endtask : t_write_readback

   // read start, zero to write start and enable clear while writing
   task automatic t_during_write();
      core.unlock_write(8'h10, 8'h3C);
      core.wr(REG_CONTROL, 8'h01);
      expect_reg(REG_CONTROL, 8'h02);
      expect_reg(REG_DATA, 8'h3C);
      wait_idle();
      expect_reg(REG_CONTROL, 8'h10);
      expect_cell(8'h10, 8'h3C);
   endtask : t_during_write

   task automatic t_unlock_faults();
      logic [15:0] seq [4][5] = '{
         '{16'h0920, 16'h8804, 16'h8955, 16'h8955, 16'h8806},
         '{16'h0920, 16'h8804, 16'h89AA, 16'h8955, 16'h8806},
         '{16'h8804, 16'h8955, 16'h0920, 16'h89AA, 16'h8806},
         '{16'h0920, 16'h8800, 16'h8955, 16'h89AA, 16'h8802}};
      core.unlock_write(8'h20, 8'h11);
      wait_idle();
      core.wr(REG_DATA, 8'h77);
      foreach (seq[i])
      begin
         foreach (seq[i][j])
            core.wr(seq[i][j][15:8], seq[i][j][7:0]);
         expect_reg(REG_CONTROL, (i == 3) ? 8'h00 : 8'h04);
      end
      expect_cell(8'h20, 8'h11);
   endtask : t_unlock_faults

   // both device resets abort a write and leave data and address alone
   task automatic t_abort();
      for (int i = 0; i < 2; i++)
      begin
         core.unlock_write(8'h21, 8'h5A);
         @(negedge core_clk);
         master_clear_reset = (i == 0);
         watchdog_reset_source = (i == 1);
         @(negedge core_clk);
         master_clear_reset = 1'b0;
         watchdog_reset_source = 1'b0;
         expect_reg(REG_CONTROL, 8'h08);
         expect_reg(REG_DATA, 8'h5A);
         expect_reg(REG_ADDRESS, 8'h21);
      end
      core.unlock_write(8'h21, 8'h5A);
      wait_idle();
      expect_reg(REG_CONTROL, 8'h14);
   endtask : t_abort

   // upper address bits set: no cell answers, no cell is written
   task automatic t_upper_addr();
      expect_cell(8'h40, 8'h00);
      core.unlock_write(8'h61, 8'hE7);
      wait_idle();
      expect_cell(8'h21, 8'h5A);
   endtask : t_upper_addr

   task automatic t_protect();
      prog(1'b1, 6'h05, 8'h96);
      check("prog ack write", {7'h00, prog_ack}, 8'h01);
      prog(1'b0, 6'h05, 8'h00);
      check("prog read", prog_rdata, 8'h96);
      code_protect = 1'b1;
      // a denied write must leave the cell untouched
      prog(1'b1, 6'h05, 8'h00);
      check("prog denied", {7'h00, prog_denied}, 8'h01);
      check("prog ack denied", {7'h00, prog_ack}, 8'h00);
      expect_cell(8'h05, 8'h96);
      core.unlock_write(8'h05, 8'h69);
      wait_idle();
      expect_cell(8'h05, 8'h69);
      code_protect = 1'b0;
   endtask : t_protect

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      sys_rst = 1'b1;
      master_clear_reset = 1'b0;
      watchdog_reset_source = 1'b0;
      code_protect = 1'b0;
      prog_req = 1'b0;
      prog_write = 1'b0;
      prog_addr = 6'h00;
      prog_wdata = 8'h00;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      t_reset_values();
      t_write_readback();
      t_during_write();
      t_unlock_faults();
      t_abort();
      t_upper_addr();
      t_protect();
      give_verdict();
   end
endmodule : data_eeprom_access_control_tb_top
